// ### core/runtime_regs_defines.svh
`ifndef RUNTIME_REGS_DEFINES_SVH
`define RUNTIME_REGS_DEFINES_SVH

// register indices: byte address is index times four
`define RT_IDX_WAKE_GSTS 7'h00
`define RT_IDX_WAKE_GEN 7'h02
`define RT_IDX_WAKE_SRC1 7'h04
`define RT_IDX_DEV_DISABLE 7'h22
`define RT_IDX_LOCK_SEL_CTL 7'h3e
`define RT_IDX_FAN_PIN_CFG 7'h4d
`define RT_IDX_GIO4 7'h4e
`define RT_IDX_GIO5 7'h4f
`define RT_IDX_GIO6 7'h50
`define RT_IDX_WDT_UNITS 7'h52
`define RT_IDX_WDT_COUNT 7'h53
`define RT_IDX_WDOG_CFG 7'h54
`define RT_IDX_WDOG_CTL 7'h55
`define RT_IDX_FAN_SPEED 7'h56
`define RT_IDX_FAN_CTRL 7'h58
`define RT_IDX_FAN_SENSE 7'h59
`define RT_IDX_FAN_PRELOAD 7'h5b
`define RT_IDX_LED_ONE 7'h5d
`define RT_IDX_LED_TWO 7'h5e
`define RT_IDX_SCAN_CODE 7'h5f
`define RT_IDX_PM_CTL1 7'h60
`define RT_IDX_PM_CTL2 7'h61
`define RT_IDX_IRQ_STS7 7'h64
`define RT_IDX_IRQ_EN7 7'h66
`define RT_IDX_WAKE_SRC7 7'h68
`define RT_IDX_WAKE_EN7 7'h6c
`define RT_IDX_RESET_CTL 7'h7f

// reset values
`define RT_RST_ZERO 8'h00
`define RT_RST_FAN_CTRL 8'h10
`define RT_RST_LED_TWO 8'h01
`define RT_RST_LOCK_SEL 8'h01

// field positions and masks
`define RT_BIT_WAKE 0
`define RT_BIT_DEVDIS_LOCK 1
`define RT_WDT_KEEP_MASK 8'h01
`define RT_WDT_RO_MASK 8'h02
`define RT_WDT_WO_MASK 8'h04
`define RT_LOCK_FIELD_MASK 8'h0c
`define RT_LOCK_FIELD_LSB 2
`define RT_LOCK_MODE 2'b01
`define RT_FAN_PIN_MASK 8'h08
`define RT_PP_ACT_BIT 0
`define RT_RST_BIT_MAIN 0
`define RT_RST_BIT_HARD 1
`define RT_RST_BIT_SOFT 2

`endif

// ### core/runtime_regs_pkg.sv
`default_nettype none
package runtime_regs_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [6:0] reg_idx_t;
    typedef enum logic [1:0] {
        bus_idle,
        bus_answer
    } bus_state_e;
endpackage : runtime_regs_pkg
`default_nettype wire

// ### core/runtime_regs_wake_event.sv
`include "runtime_regs_defines.svh"
`default_nettype none
module runtime_regs_wake_event (
    // clock and standby power-on reset
    input wire logic clk,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [8:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // wake sources, pins, asynchronous
    input wire logic kbc_port_line_a,
    input wire logic kbc_port_line_b,
    input wire logic serial_one_ring_indicate_n,
    input wire logic keyboard_wake_source,
    input wire logic mouse_wake_source,
    input wire logic specific_key_wake_source,
    input wire logic fan_speed_sense_input,
    input wire logic serial_two_ring_indicate_n,
    input wire logic [7:0] source_seven_events,
    // other pins
    input wire logic lock_select_pin,
    input wire logic printer_ack_n,
    input wire logic [7:0] fan_speed_sense_input_count_in,
    // outputs
    output logic wake_request_out_n,
    output logic parallel_irq_indication,
    output logic [7:0] watchdog_control_pulse
);
    import runtime_regs_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers
    logic [7:0] src1_s1, src1_s2, src1_d;
    logic [7:0] src7_s1, src7_s2, src7_d;
    logic lock_s1, lock_s2, ack_s1, ack_s2;
    logic [7:0] tach_s1, tach_s2;
    logic [7:0] src1_raw;
    assign src1_raw = {~serial_two_ring_indicate_n, fan_speed_sense_input, specific_key_wake_source,
        mouse_wake_source, keyboard_wake_source, ~serial_one_ring_indicate_n, kbc_port_line_b,
        kbc_port_line_a};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {src1_s1, src1_s2, src1_d} <= {3{`RT_RST_ZERO}};
            {src7_s1, src7_s2, src7_d} <= {3{`RT_RST_ZERO}};
            {lock_s1, lock_s2, ack_s1, ack_s2} <= 4'b0011;
            {tach_s1, tach_s2} <= {2{`RT_RST_ZERO}};
        end else begin
            {src1_s1, src1_s2, src1_d} <= {src1_raw, src1_s1, src1_s2};
            {src7_s1, src7_s2, src7_d} <= {source_seven_events, src7_s1, src7_s2};
            {lock_s1, lock_s2, ack_s1, ack_s2} <= {lock_select_pin, lock_s1, printer_ack_n, ack_s1};
            {tach_s1, tach_s2} <= {fan_speed_sense_input_count_in, tach_s1};
        end
    end

    logic [7:0] src1_evt, src7_evt;
    assign src1_evt = src1_s2 & ~src1_d;
    assign src7_evt = src7_s2 & ~src7_d;

    ////////////////////////////////////////////////////////////////////////
    // avalon slave: one wait cycle, answer on second edge
    bus_state_e bus_r;
    logic req, acc, wr_acc, rd_acc;
    reg_idx_t idx;
    byte_t wd;
    assign req = avs_read | avs_write;
    assign acc = req && bus_r == bus_answer;
    assign wr_acc = acc && avs_write && avs_byteenable[0];
    assign rd_acc = acc && avs_read;
    assign idx = avs_address[8:2];
    assign wd = avs_writedata[7:0];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus_r <= bus_idle;
        end else begin
            unique case (bus_r)
                bus_idle: begin
                    if (req) begin
                        bus_r <= bus_answer;
                    end
                end
                bus_answer: begin
                    bus_r <= bus_idle;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !(req && bus_r == bus_idle);
        end
    end

    function automatic logic hit(input reg_idx_t a, input reg_idx_t b);
        hit = (a == b);
    endfunction : hit

    function automatic byte_t w1c(input byte_t cur, input byte_t evt, input byte_t clr);
        // set wins over clear
        w1c = (cur & ~clr) | evt;
    endfunction : w1c

    ////////////////////////////////////////////////////////////////////////
    // reset-control register: software-issued main, hard and soft resets
    logic main_rst_p, hard_rst_p, soft_rst_p, sys_rst_p;
    assign main_rst_p = wr_acc && hit(idx, `RT_IDX_RESET_CTL) && wd[`RT_RST_BIT_MAIN];
    assign hard_rst_p = wr_acc && hit(idx, `RT_IDX_RESET_CTL) && wd[`RT_RST_BIT_HARD];
    assign soft_rst_p = wr_acc && hit(idx, `RT_IDX_RESET_CTL) && wd[`RT_RST_BIT_SOFT];
    assign sys_rst_p = main_rst_p | hard_rst_p;

    ////////////////////////////////////////////////////////////////////////
    // wake flag, enable and source status
    logic wake_flag_r, wake_output_enable_r;
    byte_t src1_r, src7_r, en7_r;
    logic wake_cause;
    assign wake_cause = |src1_evt | |(src7_evt & en7_r);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wake_flag_r <= 1'b0;
        end else if (wake_cause) begin
            wake_flag_r <= 1'b1;
        end else if (wr_acc && hit(idx, `RT_IDX_WAKE_GSTS) && wd[`RT_BIT_WAKE]) begin
            wake_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wake_output_enable_r <= 1'b0;
        end else if (wr_acc && hit(idx, `RT_IDX_WAKE_GEN)) begin
            wake_output_enable_r <= wd[`RT_BIT_WAKE];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            src1_r <= `RT_RST_ZERO;
            src7_r <= `RT_RST_ZERO;
        end else begin
            src1_r <= w1c(src1_r, src1_evt,
                (wr_acc && hit(idx, `RT_IDX_WAKE_SRC1)) ? wd : `RT_RST_ZERO);
            src7_r <= w1c(src7_r, src7_evt,
                (wr_acc && hit(idx, `RT_IDX_WAKE_SRC7)) ? wd : `RT_RST_ZERO);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wake_request_out_n <= 1'b1;
        end else begin
            // active only when flag and enable
            wake_request_out_n <= !(wake_flag_r && wake_output_enable_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // plain standby-domain registers
    byte_t gio4_r, gio5_r, gio6_r, fan_speed_r, fan_ctrl_r, preload_r, light_one_r, light_two_r;
    byte_t scan_r, pm1_r, pm2_r, irq_sts7_r, irq_en7_r, devdis_r, lock_ctl_r, fan_pin_r;
    logic devdis_ro;
    assign devdis_ro = (lock_ctl_r[`RT_LOCK_FIELD_LSB +: 2] == `RT_LOCK_MODE && lock_s2)
        || devdis_r[`RT_BIT_DEVDIS_LOCK];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {gio4_r, gio5_r, gio6_r, fan_speed_r, preload_r, light_one_r} <= {6{`RT_RST_ZERO}};
            {scan_r, pm1_r, pm2_r, irq_sts7_r, irq_en7_r, en7_r, devdis_r} <= {7{`RT_RST_ZERO}};
            fan_ctrl_r <= `RT_RST_FAN_CTRL;
            light_two_r <= `RT_RST_LED_TWO;
        end else if (wr_acc) begin
            unique case (idx)
                `RT_IDX_GIO4: gio4_r <= wd;
                `RT_IDX_GIO5: gio5_r <= wd;
                `RT_IDX_GIO6: gio6_r <= wd;
                `RT_IDX_FAN_SPEED: fan_speed_r <= wd;
                `RT_IDX_FAN_CTRL: fan_ctrl_r <= wd;
                `RT_IDX_FAN_PRELOAD: preload_r <= wd;
                `RT_IDX_LED_ONE: light_one_r <= wd;
                `RT_IDX_LED_TWO: light_two_r <= wd;
                `RT_IDX_SCAN_CODE: scan_r <= wd;
                `RT_IDX_PM_CTL1: pm1_r <= wd;
                `RT_IDX_PM_CTL2: pm2_r <= wd;
                `RT_IDX_IRQ_STS7: irq_sts7_r <= wd;
                `RT_IDX_IRQ_EN7: irq_en7_r <= wd;
                `RT_IDX_WAKE_EN7: en7_r <= wd;
                `RT_IDX_DEV_DISABLE: begin
                    if (!devdis_ro) begin
                        devdis_r <= wd;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // these fields also clear on main and hard reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lock_ctl_r <= `RT_RST_LOCK_SEL;
            fan_pin_r <= `RT_RST_ZERO;
        end else if (sys_rst_p) begin
            lock_ctl_r <= lock_ctl_r & ~`RT_LOCK_FIELD_MASK;
            fan_pin_r <= fan_pin_r & ~`RT_FAN_PIN_MASK;
        end else if (wr_acc && hit(idx, `RT_IDX_LOCK_SEL_CTL)) begin
            lock_ctl_r <= wd;
        end else if (wr_acc && hit(idx, `RT_IDX_FAN_PIN_CFG)) begin
            fan_pin_r <= wd;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // watchdog registers, all resets except soft
    byte_t wdt_units_r, wdt_count_r, wdog_cfg_r, wdog_ctl_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wdt_units_r <= `RT_RST_ZERO;
            wdt_count_r <= `RT_RST_ZERO;
            wdog_cfg_r <= `RT_RST_ZERO;
            wdog_ctl_r <= `RT_RST_ZERO;
        end else if (sys_rst_p) begin
            wdt_units_r <= `RT_RST_ZERO;
            wdt_count_r <= `RT_RST_ZERO;
            wdog_cfg_r <= `RT_RST_ZERO;
            // bit zero kept over hard reset, main clears all
            wdog_ctl_r <= main_rst_p ? `RT_RST_ZERO : (wdog_ctl_r & `RT_WDT_KEEP_MASK);
        end else if (wr_acc) begin
            unique case (idx)
                `RT_IDX_WDT_UNITS: wdt_units_r <= wd;
                `RT_IDX_WDT_COUNT: wdt_count_r <= wd;
                `RT_IDX_WDOG_CFG: wdog_cfg_r <= wd;
                // read-only and write-only bits not stored
                `RT_IDX_WDOG_CTL: wdog_ctl_r <= (wdog_ctl_r & `RT_WDT_RO_MASK)
                    | (wd & ~(`RT_WDT_RO_MASK | `RT_WDT_WO_MASK));
                default: begin
                end
            endcase
        end
    end

    // write-only bits act as one-cycle pulses
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            watchdog_control_pulse <= `RT_RST_ZERO;
        end else begin
            watchdog_control_pulse <= (wr_acc && hit(idx, `RT_IDX_WDOG_CTL)) ? (wd & `RT_WDT_WO_MASK)
                : `RT_RST_ZERO;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // parallel irq indication
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            parallel_irq_indication <= 1'b1;
        end else begin
            // one when idle, else ack level
            parallel_irq_indication <= pm1_r[`RT_PP_ACT_BIT] ? ack_s2 : 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux
    byte_t rd_mux;
    always_comb begin
        rd_mux = `RT_RST_ZERO;
        unique case (idx)
            `RT_IDX_WAKE_GSTS: rd_mux = {7'h00, wake_flag_r};
            `RT_IDX_WAKE_GEN: rd_mux = {7'h00, wake_output_enable_r};
            `RT_IDX_WAKE_SRC1: rd_mux = src1_r;
            `RT_IDX_DEV_DISABLE: rd_mux = devdis_r;
            `RT_IDX_LOCK_SEL_CTL: rd_mux = lock_ctl_r;
            `RT_IDX_FAN_PIN_CFG: rd_mux = fan_pin_r;
            `RT_IDX_GIO4: rd_mux = gio4_r;
            `RT_IDX_GIO5: rd_mux = gio5_r;
            `RT_IDX_GIO6: rd_mux = gio6_r;
            `RT_IDX_WDT_UNITS: rd_mux = wdt_units_r;
            `RT_IDX_WDT_COUNT: rd_mux = wdt_count_r;
            `RT_IDX_WDOG_CFG: rd_mux = wdog_cfg_r;
            `RT_IDX_WDOG_CTL: rd_mux = wdog_ctl_r & ~`RT_WDT_WO_MASK;
            `RT_IDX_FAN_SPEED: rd_mux = fan_speed_r;
            `RT_IDX_FAN_CTRL: rd_mux = fan_ctrl_r;
            `RT_IDX_FAN_SENSE: rd_mux = tach_s2;
            `RT_IDX_FAN_PRELOAD: rd_mux = preload_r;
            `RT_IDX_LED_ONE: rd_mux = light_one_r;
            `RT_IDX_LED_TWO: rd_mux = light_two_r;
            `RT_IDX_SCAN_CODE: rd_mux = scan_r;
            `RT_IDX_PM_CTL1: rd_mux = pm1_r;
            `RT_IDX_PM_CTL2: rd_mux = pm2_r;
            `RT_IDX_IRQ_STS7: rd_mux = irq_sts7_r;
            `RT_IDX_IRQ_EN7: rd_mux = irq_en7_r;
            `RT_IDX_WAKE_SRC7: rd_mux = src7_r;
            `RT_IDX_WAKE_EN7: rd_mux = en7_r;
            default: rd_mux = `RT_RST_ZERO;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (req && bus_r == bus_idle && avs_read) begin
            avs_readdata <= {24'h00_0000, rd_mux};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_flag_and_enable;
        wake_flag_r && wake_output_enable_r;
    endsequence

    a_wake_out_follow: assert property (@(posedge clk) disable iff (rst)
        s_flag_and_enable |=> !wake_request_out_n)
        else $error("wake output not driven while flag and enable set");
    a_wake_out_block: assert property (@(posedge clk) disable iff (rst)
        !wake_output_enable_r |=> wake_request_out_n)
        else $error("wake output driven while disabled");
    a_flag_sets: assert property (@(posedge clk) disable iff (rst)
        wake_cause |=> wake_flag_r)
        else $error("wake flag not set by wake cause");
    a_flag_clear_one: assert property (@(posedge clk) disable iff (rst)
        wr_acc && hit(idx, `RT_IDX_WAKE_GSTS) && wd[`RT_BIT_WAKE] && !wake_cause
        |=> !wake_flag_r ##1 wake_request_out_n)
        else $error("write one did not clear wake flag");
    a_flag_zero_keep: assert property (@(posedge clk) disable iff (rst)
        wake_flag_r && !(wr_acc && hit(idx, `RT_IDX_WAKE_GSTS) && wd[`RT_BIT_WAKE]) |=> wake_flag_r)
        else $error("wake flag lost without clearing write");
    a_src_sticky: assert property (@(posedge clk) disable iff (rst)
        |src1_evt |=> (src1_r & $past(src1_evt)) == $past(src1_evt))
        else $error("source event not captured");
    a_src_clear: assert property (@(posedge clk) disable iff (rst)
        wr_acc && hit(idx, `RT_IDX_WAKE_SRC1) && src1_evt == 8'h00 |=> (src1_r & $past(wd)) == 8'h00)
        else $error("source status not cleared by write one");
    a_devdis_lock: assert property (@(posedge clk) disable iff (rst)
        devdis_ro |=> $stable(devdis_r))
        else $error("device disable written while locked");
    a_wdt_keep: assert property (@(posedge clk) disable iff (rst)
        hard_rst_p && !main_rst_p |=> wdog_ctl_r == ($past(wdog_ctl_r) & `RT_WDT_KEEP_MASK))
        else $error("watchdog control wrong after hard reset");
    a_soft_rst_keep: assert property (@(posedge clk) disable iff (rst)
        soft_rst_p && !sys_rst_p |=> $stable(wdog_ctl_r) && $stable(lock_ctl_r) && $stable(gio4_r))
        else $error("soft reset altered a register");
    a_lock_clear: assert property (@(posedge clk) disable iff (rst)
        sys_rst_p |=> (lock_ctl_r & `RT_LOCK_FIELD_MASK) == 8'h00 && (fan_pin_r & `RT_FAN_PIN_MASK) == 8'h00)
        else $error("lock or fan pin field not cleared");
    a_pp_irq_idle: assert property (@(posedge clk) disable iff (rst)
        !pm1_r[`RT_PP_ACT_BIT] |=> parallel_irq_indication)
        else $error("parallel irq indication low while inactive");
    a_bus_answer: assert property (@(posedge clk) disable iff (rst)
        req && avs_waitrequest |-> ##[0:2] !avs_waitrequest)
        else $error("bus request not answered");
endmodule : runtime_regs_wake_event
`default_nettype wire

// ### test/wake_sink_model.sv
`default_nettype none
module wake_sink_model (
    // clock and observed wake line
    input wire logic clk,
    input wire logic wake_n,
    // count of assertions seen
    output int wake_count
);
    timeunit 1ns;
    timeprecision 1ns;
    logic last_r;
    initial last_r = 1'b1;
    initial wake_count = 0;
    always @(posedge clk) begin
        last_r <= wake_n;
        if (last_r === 1'b1 && wake_n === 1'b0) begin
            wake_count <= wake_count + 1;
        end
    end
endmodule : wake_sink_model
`default_nettype wire

// ### test/test_runtime_regs_wake_event.sv
`default_nettype none
module test_runtime_regs_wake_event;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst, avs_read, avs_write, lock_pin, ack_n, wake_n, pp_irq;
    logic [8:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic avs_waitrequest;
    logic [7:0] src, src7, rdv, wdt_pulse;
    int err_total, checks, wake_count, i;
    logic [6:0] idx_tab [12] = '{7'h00, 7'h02, 7'h04, 7'h51, 7'h57, 7'h59, 7'h5a, 7'h58, 7'h5e, 7'h3e, 7'h7e, 7'h6d};
    logic [7:0] exp_tab [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h5a, 8'h00, 8'h10, 8'h01, 8'h01, 8'h00, 8'h00};
    ////////////////////////////////////////////////////////////
    runtime_regs_wake_event runtime_regs_wake_event_inst (
        .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'h1), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .kbc_port_line_a(src[0]), .kbc_port_line_b(src[1]),
        .serial_one_ring_indicate_n(~src[2]), .keyboard_wake_source(src[3]), .mouse_wake_source(src[4]),
        .specific_key_wake_source(src[5]), .fan_speed_sense_input(src[6]),
        .serial_two_ring_indicate_n(~src[7]), .source_seven_events(src7), .lock_select_pin(lock_pin),
        .printer_ack_n(ack_n), .fan_speed_sense_input_count_in(8'h5a), .wake_request_out_n(wake_n),
        .parallel_irq_indication(pp_irq), .watchdog_control_pulse(wdt_pulse)
    );
    wake_sink_model wake_sink_model_inst (.clk(clk), .wake_n(wake_n), .wake_count(wake_count));
    ////////////////////////////////////////////////////////////
    task automatic conclude();
        if (err_total == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one avalon transfer, held until waitrequest is seen low
    task automatic xfer(input logic wr, input logic [6:0] idx, input logic [7:0] d);
        int n;
        @(posedge clk);
        avs_read <= !wr;
        avs_write <= wr;
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h0, d};
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0) break;
        end
        rdv = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n == 40) begin
            err_total++;
            conclude();
        end
    endtask : xfer
    task automatic wr(input logic [6:0] idx, input logic [7:0] d);
        xfer(1'b1, idx, d);
    endtask : wr
    task automatic rd_chk(input logic [6:0] idx, input logic [7:0] exp);
        xfer(1'b0, idx, 8'h00);
        chk(rdv, exp);
    endtask : rd_chk
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle
    // software reset, then standby-only registers must hold
    task automatic rst_chk(input logic [7:0] v);
        wr(7'h7f, v);
        rd_chk(7'h00, 8'h01);
        rd_chk(7'h02, 8'h01);
        rd_chk(7'h04, 8'h18);
        rd_chk(7'h4e, 8'ha5);
    endtask : rst_chk
    ////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        {rst, avs_read, avs_write, lock_pin, ack_n} = 5'b10001;
        avs_address = 9'h000;
        avs_writedata = 32'h0;
        src = 8'h00;
        src7 = 8'h00;
        err_total = 0;
        checks = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < 12; i++) rd_chk(idx_tab[i], exp_tab[i]);
        wr(7'h02, 8'hff);
        rd_chk(7'h02, 8'h01);
        wr(7'h02, 8'h00);
        for (i = 0; i < 8; i++) begin
            src[i] <= 1'b1;
            idle(6);
            rd_chk(7'h04, 8'h01 << i);
            wr(7'h04, 8'h00);
            rd_chk(7'h04, 8'h01 << i);
            wr(7'h04, 8'h01 << i);
            rd_chk(7'h04, 8'h00);
            src[i] <= 1'b0;
        end
        rd_chk(7'h00, 8'h01);
        chk({7'h0, wake_n}, 8'h01);
        wr(7'h00, 8'h00);
        rd_chk(7'h00, 8'h01);
        wr(7'h00, 8'h01);
        rd_chk(7'h00, 8'h00);
        wr(7'h02, 8'h01);
        chk({7'h0, wake_n}, 8'h01);
        src[3] <= 1'b1;
        idle(6);
        chk({7'h0, wake_n}, 8'h00);
        wr(7'h00, 8'h00);
        chk({7'h0, wake_n}, 8'h00);
        wr(7'h00, 8'h01);
        idle(2);
        chk({7'h0, wake_n}, 8'h01);
        src[4] <= 1'b1;
        idle(6);
        wr(7'h4e, 8'ha5);
        wr(7'h55, 8'hff);
        idle(1);
        chk(wdt_pulse, 8'h04);
        rd_chk(7'h55, 8'hf9);
        chk(wdt_pulse, 8'h00);
        wr(7'h3e, 8'h0d);
        wr(7'h4d, 8'hff);
        rst_chk(8'h04);
        rst_chk(8'h02);
        rd_chk(7'h55, 8'h01);
        rd_chk(7'h3e, 8'h01);
        rd_chk(7'h4d, 8'hf7);
        rst_chk(8'h01);
        wr(7'h00, 8'h01);
        wr(7'h3e, 8'h05);
        lock_pin <= 1'b1;
        idle(4);
        wr(7'h22, 8'h10);
        rd_chk(7'h22, 8'h00);
        lock_pin <= 1'b0;
        idle(4);
        wr(7'h22, 8'h12);
        wr(7'h22, 8'h00);
        rd_chk(7'h22, 8'h12);
        ack_n <= 1'b0;
        idle(4);
        chk({7'h0, pp_irq}, 8'h01);
        wr(7'h60, 8'h01);
        idle(4);
        chk({7'h0, pp_irq}, 8'h00);
        ack_n <= 1'b1;
        idle(4);
        chk({7'h0, pp_irq}, 8'h01);
        src7[0] <= 1'b1;
        idle(6);
        rd_chk(7'h68, 8'h01);
        rd_chk(7'h00, 8'h00);
        wr(7'h68, 8'h01);
        rd_chk(7'h68, 8'h00);
        wr(7'h6c, 8'h02);
        src7[1] <= 1'b1;
        idle(6);
        rd_chk(7'h00, 8'h01);
        chk(wake_count[7:0], 8'h03);
        conclude();
    end
endmodule : test_runtime_regs_wake_event
`default_nettype wire
